/* scpe_encoder.sv */
// single-carrier payload encoder: bits in, sc block symbols out
// Function
// - training symbol count header field is driven as all zeros
// - equal protection bits are scrambled, then padded, then rs coded
// - zero bits pad each data block to a multiple of 1792 bits, each header block to a multiple of 192
// - coded or header bits split four ways, interleaved, recombined
// - multiplexed bits are mapped, then spread in time
// - zero symbols pad the stream to a multiple of 504 symbols
// - padded symbols go through symbol interleaving then differential coding (no symbol interleaver here: differential coding only)
// - differential coder restarts every 252 symbols, else multiplies by prior
// - receiver may seed its decoder from last ce or pilot symbol
// - unequal protection splits octet high and low bits into two coded groups
// - unequal protection uses eight branches, then one multiplexed stream
// - unequal protection symbols padded to 504 multiple, then interleaved (no symbol interleaver here: sent as padded)
// - dbpsk maps each bit to minus one or plus one
// - dqpsk pairs map 00 -1, 01 +j, 10 -j, 11 +1
// - earlier serial bit is the first bit of each dqpsk pair
// - normalisation factor is one
// - every 252 data symbols are followed by 4 pilots
// - pilots run -1, +1, -1, +1
// - midamble repeats the preamble channel estimation sequence
// - channel estimation sequence is 768 symbols of plus or minus one
// - header bits take the basic mode path after the demultiplexer
`timescale 1ns/1ps
module scpe_encoder #(
  parameter int          TDSF_W   = 4,
  parameter logic [14:0] SCR_SEED = scpe_pkg::SCR_SEED,
  parameter logic [10:0] CE_SEED  = scpe_pkg::CE_SEED
) (
  input  wire logic              i_mclk,
  input  wire logic              i_resetn,
  input  wire logic              i_bit_valid,
  input  wire logic              i_bit,
  input  wire logic              i_bit_last,
  input  wire logic              i_hdr,
  input  wire logic [1:0]        i_mode,
  output logic                   o_bit_ready,
  output logic                   o_rs_valid,
  output logic                   o_rs_bit,
  output logic                   o_rs_last,
  output logic                   o_rs_raw,
  input  wire logic              i_rs_ready,
  input  wire logic              i_rs_valid,
  input  wire logic              i_rs_bit,
  input  wire logic              i_rs_last,
  input  wire logic              i_rs_raw,
  output logic                   o_rs_ready,
  input  wire logic [TDSF_W-1:0] i_tdsf,
  input  wire logic              i_ce_req,
  output logic                   o_sym_valid,
  output logic [1:0]             o_sym_re,
  output logic [1:0]             o_sym_im,
  output logic                   o_sym_pilot,
  output logic                   o_sym_ce,
  output logic                   o_sym_last,
  input  wire logic              i_sym_ready,
  output logic [5:0]             o_tx_training_symbol_count
);
  localparam logic [10:0] RS_LAST  = 11'(scpe_pkg::RS_BLOCK_BITS - 1);
  localparam logic [10:0] HDR_LAST = 11'(scpe_pkg::HDR_BLOCK_BITS - 1);
  localparam logic [7:0]  D_LAST   = 8'(scpe_pkg::DATA_SYMS - 1);
  localparam logic [1:0]  P_LAST   = 2'(scpe_pkg::PILOT_SYMS - 1);
  localparam logic [9:0]  CE_LAST  = 10'(scpe_pkg::CE_SYMS - 1);

  function automatic logic [1:0] map_pair(input logic g0, input logic g1);
    logic [1:0] ph;
    ph = scpe_pkg::PH_M1;
    unique case ({g0, g1})
      2'h0: ph = scpe_pkg::PH_M1;
      2'h1: ph = scpe_pkg::PH_PJ;
      2'h2: ph = scpe_pkg::PH_MJ;
      2'h3: ph = scpe_pkg::PH_P1;
    endcase
    return ph;
  endfunction

  // ----------------------------------------------------------------
  // stage a: octet split, scramble, zero pad
  // ----------------------------------------------------------------
  scpe_pkg::scpe_bits_e sa;
  logic [10:0] cnt0;
  logic [10:0] cnt1;
  logic [14:0] scr0;
  logic [14:0] scr1;
  logic [2:0]  oct;
  logic        pad_grp;
  logic        blk_raw;
  logic        blk_uep;

  wire        a_pop     = o_rs_valid & i_rs_ready;
  wire        a_free    = !o_rs_valid | a_pop;
  wire        in_fire   = o_bit_ready & i_bit_valid;
  wire        in_uep    = (i_mode == scpe_pkg::MODE_UEP) & !i_hdr;
  wire        in_grp    = in_uep & oct[2];
  wire        pad_fire  = (sa == scpe_pkg::SA_PAD) & a_free;
  wire        a_push    = in_fire | pad_fire;
  wire        cur_grp   = pad_fire ? pad_grp : in_grp;
  wire        cur_raw   = pad_fire ? blk_raw : i_hdr;
  wire [10:0] gran_last = cur_raw ? HDR_LAST : RS_LAST;
  wire [10:0] cnt_cur   = cur_grp ? cnt1 : cnt0;
  wire        cnt_wrap  = cnt_cur == gran_last;
  wire [10:0] cnt_nx    = cnt_wrap ? 11'h000 : cnt_cur + 11'h001;
  wire [14:0] scr_cur   = in_grp ? scr1 : scr0;
  wire        scr_fb    = ^(scr_cur & scpe_pkg::SCR_TAPS);
  wire        need0     = in_grp ? (cnt0 != 11'h000) : !cnt_wrap;
  wire        need1     = in_uep & (in_grp ? !cnt_wrap : (cnt1 != 11'h000));
  wire        data_end  = in_fire & i_bit_last;
  wire        start_pad = data_end & (need0 | need1);
  wire        more1     = !pad_grp & blk_uep & (cnt1 != 11'h000);
  wire        pad_done  = pad_fire & cnt_wrap & !more1;
  wire        blk_end_a = (data_end & !(need0 | need1)) | pad_done;
  wire        next_pad  = start_pad | ((sa == scpe_pkg::SA_PAD) & !pad_done);
  wire        next_a_v  = a_push | (o_rs_valid & !a_pop);

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_rs_valid  <= 1'b0;
      o_rs_bit    <= 1'b0;
      o_rs_last   <= 1'b0;
      o_rs_raw    <= 1'b0;
      o_bit_ready <= 1'b0;
      sa          <= scpe_pkg::SA_DATA;
      cnt0        <= 11'h000;
      cnt1        <= 11'h000;
      scr0        <= SCR_SEED;
      scr1        <= SCR_SEED;
      oct         <= 3'h0;
      pad_grp     <= 1'b0;
      blk_raw     <= 1'b0;
      blk_uep     <= 1'b0;
    end else begin
      o_rs_valid  <= next_a_v;
      o_bit_ready <= !next_a_v & !next_pad;
      sa          <= next_pad ? scpe_pkg::SA_PAD : scpe_pkg::SA_DATA;
      if (a_push) begin
        o_rs_bit  <= in_fire & (i_bit ^ (scr_fb & !i_hdr));
        o_rs_last <= blk_end_a;
        o_rs_raw  <= cur_raw;
      end
      if (a_push & !cur_grp) cnt0 <= cnt_nx;
      if (a_push & cur_grp) cnt1 <= cnt_nx;
      if (in_fire) begin
        oct     <= oct + 3'h1;
        blk_raw <= i_hdr;
        blk_uep <= in_uep;
      end
      if (in_fire & !i_hdr & !in_grp) scr0 <= {scr0[13:0], scr_fb};
      if (in_fire & !i_hdr & in_grp) scr1 <= {scr1[13:0], scr_fb};
      if (start_pad) pad_grp <= !need0;
      else if (pad_fire & cnt_wrap & more1) pad_grp <= 1'b1;
      if (blk_end_a) begin
        scr0 <= SCR_SEED;
        scr1 <= SCR_SEED;
        oct  <= 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // stage b: constellation mapping of coded bits
  // ----------------------------------------------------------------
  logic       b_valid;
  logic [1:0] b_ph;
  logic       b_last;
  logic       b_half;
  logic       b_first;
  logic       c_take_b;
  logic       b_raw;

  wire       b_in       = o_rs_ready & i_rs_valid;
  wire       b_pairmode = !i_rs_raw & (i_mode != scpe_pkg::MODE_BASIC);
  wire       b_push     = b_in & (!b_pairmode | b_half | i_rs_last);
  wire       b_g0       = b_half ? b_first : i_rs_bit;
  wire       b_g1       = b_half & i_rs_bit;
  wire [1:0] b_ph_nx    = b_pairmode ? map_pair(b_g0, b_g1)
                        : (i_rs_bit ? scpe_pkg::PH_P1 : scpe_pkg::PH_M1);
  wire       b_pop      = b_valid & c_take_b;
  wire       next_b_v   = b_push | (b_valid & !b_pop);

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      b_valid    <= 1'b0;
      b_ph       <= scpe_pkg::PH_M1;
      b_last     <= 1'b0;
      b_half     <= 1'b0;
      b_first    <= 1'b0;
      b_raw      <= 1'b0;
      o_rs_ready <= 1'b0;
    end else begin
      b_valid    <= next_b_v;
      o_rs_ready <= !next_b_v;
      if (b_push) begin
        b_ph   <= b_ph_nx;
        b_last <= i_rs_last;
        b_raw  <= i_rs_raw;
      end
      if (b_in & b_pairmode & !b_half & !i_rs_last) begin
        b_half  <= 1'b1;
        b_first <= i_rs_bit;
      end else if (b_in) begin
        b_half <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // stage c: spreading, symbol pad, differential code, sc blocks
  // ----------------------------------------------------------------
  scpe_pkg::scpe_sym_e sc;
  logic [TDSF_W-1:0] rep;
  logic [7:0]        dcnt;
  logic              half;
  logic              tail;
  logic [1:0]        pidx;
  logic [9:0]        ce_idx;
  logic [10:0]       ce_lfsr;
  logic              ce_pend;
  logic [1:0]        tprev;
  logic              prev_vz;

  wire              c_free   = !o_sym_valid | i_sym_ready;
  wire [TDSF_W-1:0] rep_last = (i_tdsf == '0) ? '0 : i_tdsf - TDSF_W'(1);
  wire              d_fire   = c_free & (sc == scpe_pkg::SC_DATA) & (tail | b_valid);
  wire              pil_fire = c_free & (sc == scpe_pkg::SC_PILOT);
  wire              ce_fire  = c_free & (sc == scpe_pkg::SC_CE);
  wire              e_fire   = d_fire | pil_fire | ce_fire;
  wire              idle_ce  = c_free & (sc == scpe_pkg::SC_DATA) & !tail & !b_valid
                             & (dcnt == 8'h00) & !half & ce_pend;
  wire              rep_end  = rep == rep_last;
  assign c_take_b = d_fire & !tail & rep_end;
  wire              blk_end  = d_fire & (dcnt == D_LAST);
  wire              pil_end  = pil_fire & (pidx == P_LAST);
  wire              done     = pil_end & tail & !half;
  wire              ce_start = idle_ce | (pil_end & !done & ce_pend);
  wire              ce_end   = ce_fire & (ce_idx == CE_LAST);
  wire              ce_fb    = ^(ce_lfsr & scpe_pkg::CE_TAPS);
  wire              vz       = tail;
  wire              no_diff  = (i_mode == scpe_pkg::MODE_UEP) & !b_raw;
  wire              restart  = (dcnt == 8'h00) | prev_vz | no_diff;
  wire [1:0]        t_ph     = restart ? b_ph : tprev + b_ph;
  wire [1:0]        e_ph     = ce_fire ? (ce_lfsr[0] ? scpe_pkg::PH_P1 : scpe_pkg::PH_M1)
                             : pil_fire ? (pidx[0] ? scpe_pkg::PH_P1 : scpe_pkg::PH_M1)
                             : t_ph;
  wire              e_z      = d_fire & vz;
  wire [1:0]        e_re     = e_z ? 2'h0 : (e_ph == scpe_pkg::PH_P1) ? 2'h1
                             : (e_ph == scpe_pkg::PH_M1) ? 2'h3 : 2'h0;
  wire [1:0]        e_im     = e_z ? 2'h0 : (e_ph == scpe_pkg::PH_PJ) ? 2'h1
                             : (e_ph == scpe_pkg::PH_MJ) ? 2'h3 : 2'h0;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      sc          <= scpe_pkg::SC_DATA;
      rep         <= '0;
      dcnt        <= 8'h00;
      half        <= 1'b0;
      tail        <= 1'b0;
      pidx        <= 2'h0;
      ce_idx      <= 10'h000;
      ce_lfsr     <= CE_SEED;
      ce_pend     <= 1'b0;
      tprev       <= scpe_pkg::PH_P1;
      prev_vz     <= 1'b0;
      o_sym_valid <= 1'b0;
      o_sym_re    <= 2'h0;
      o_sym_im    <= 2'h0;
      o_sym_pilot <= 1'b0;
      o_sym_ce    <= 1'b0;
      o_sym_last  <= 1'b0;
      o_tx_training_symbol_count <= scpe_pkg::TXTS_VALUE;
    end else begin
      o_tx_training_symbol_count <= scpe_pkg::TXTS_VALUE;
      o_sym_valid <= e_fire | (o_sym_valid & !i_sym_ready);
      if (e_fire) begin
        o_sym_re    <= e_re;
        o_sym_im    <= e_im;
        o_sym_pilot <= pil_fire;
        o_sym_ce    <= ce_fire;
        o_sym_last  <= done;
      end
      ce_pend <= i_ce_req | (ce_pend & !ce_start);
      if (d_fire & !tail) rep <= rep_end ? '0 : rep + TDSF_W'(1);
      if (d_fire) begin
        dcnt    <= blk_end ? 8'h00 : dcnt + 8'h01;
        tprev   <= t_ph;
        prev_vz <= vz;
      end
      if (blk_end) half <= !half;
      if (c_take_b & b_last) tail <= 1'b1;
      if (done) tail <= 1'b0;
      if (pil_fire) pidx <= pidx + 2'h1;
      if (ce_start) begin
        ce_idx  <= 10'h000;
        ce_lfsr <= CE_SEED;
      end else if (ce_fire) begin
        ce_idx  <= ce_idx + 10'h001;
        ce_lfsr <= {ce_lfsr[9:0], ce_fb};
      end
      unique case (sc)
        scpe_pkg::SC_DATA: begin
          if (blk_end) sc <= scpe_pkg::SC_PILOT;
          else if (idle_ce) sc <= scpe_pkg::SC_CE;
        end
        scpe_pkg::SC_PILOT: begin
          if (pil_end) sc <= ce_start ? scpe_pkg::SC_CE : scpe_pkg::SC_DATA;
        end
        scpe_pkg::SC_CE: begin
          if (ce_end) sc <= scpe_pkg::SC_DATA;
        end
        default: sc <= scpe_pkg::SC_DATA;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [1:0] out_pidx;
  logic [8:0] dout;
  logic [9:0] ce_run;
  wire        o_fire = o_sym_valid & i_sym_ready;

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      out_pidx <= 2'h0;
      dout     <= 9'h000;
      ce_run   <= 10'h000;
    end else begin
      if (o_fire & o_sym_pilot) out_pidx <= out_pidx + 2'h1;
      if (o_fire & o_sym_pilot & (out_pidx == P_LAST)) dout <= 9'h000;
      else if (o_fire & !o_sym_pilot & !o_sym_ce) dout <= dout + 9'h001;
      if (o_fire & o_sym_ce) ce_run <= ce_run + 10'h001;
      else if (o_fire) ce_run <= 10'h000;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  sequence s_stall;
    o_sym_valid & !i_sym_ready;
  endsequence
  sequence s_pair_push;
    b_push & b_pairmode;
  endsequence

  AST_TXTS_ZERO: assert property (o_tx_training_symbol_count == 6'h00)
    else $error("training symbol count not zero");
  AST_BIT_PAD: assert property (o_rs_valid & o_rs_last |-> (cnt0 == 11'h000)
    && (cnt1 == 11'h000))
    else $error("coded block not padded to whole granule");
  AST_PILOT_VAL: assert property (o_sym_valid & o_sym_pilot
    |-> o_sym_re == (out_pidx[0] ? 2'h1 : 2'h3) && o_sym_im == 2'h0)
    else $error("pilot value wrong");
  AST_BLOCK_LEN: assert property (o_sym_valid & o_sym_pilot & (out_pidx == 2'h0)
    |-> dout == 9'(scpe_pkg::DATA_SYMS))
    else $error("data block length not 252");
  AST_DIFF_RESET: assert property (d_fire & (dcnt == 8'h00) & !tail
    |=> o_sym_re == (($past(b_ph) == scpe_pkg::PH_P1) ? 2'h1
       : ($past(b_ph) == scpe_pkg::PH_M1) ? 2'h3 : 2'h0))
    else $error("block start not passed through");
  AST_DIFF_CHAIN: assert property (d_fire & (dcnt != 8'h00) & !tail & !prev_vz & !no_diff
    |=> tprev == $past(tprev) + $past(b_ph))
    else $error("differential product wrong");
  AST_DQPSK_MAP: assert property (s_pair_push
    |=> b_ph == (({$past(b_g0), $past(b_g1)} == 2'h3) ? scpe_pkg::PH_P1
       : ({$past(b_g0), $past(b_g1)} == 2'h0) ? scpe_pkg::PH_M1
       : $past(b_g0) ? scpe_pkg::PH_MJ : scpe_pkg::PH_PJ))
    else $error("dqpsk mapping wrong");
  AST_DBPSK_MAP: assert property (b_push & !b_pairmode
    |=> b_ph == ($past(i_rs_bit) ? scpe_pkg::PH_P1 : scpe_pkg::PH_M1))
    else $error("dbpsk mapping wrong");
  AST_CE_LEN: assert property (o_fire & !o_sym_ce & (ce_run != 10'h000)
    |-> ce_run == 10'(scpe_pkg::CE_SYMS))
    else $error("ce sequence length not 768");
  AST_SYM_PAD: assert property (o_sym_valid & o_sym_last
    |-> (dcnt == 8'h00) && !half && (sc == scpe_pkg::SC_DATA))
    else $error("symbol stream not padded to 504");
  AST_HOLD: assert property (s_stall |=> o_sym_valid && $stable(o_sym_re)
    && $stable(o_sym_im))
    else $error("symbol dropped under stall");
  AST_UEP_PLAIN: assert property (d_fire & no_diff & !tail
    |=> o_sym_re == (($past(b_ph) == scpe_pkg::PH_P1) ? 2'h1
       : ($past(b_ph) == scpe_pkg::PH_M1) ? 2'h3 : 2'h0)
    && o_sym_im == (($past(b_ph) == scpe_pkg::PH_PJ) ? 2'h1
       : ($past(b_ph) == scpe_pkg::PH_MJ) ? 2'h3 : 2'h0))
    else $error("unequal protection symbol not passed through");
endmodule

/* scpe_pkg.sv */
// shared constants and types for the single-carrier payload encoder
package scpe_pkg;
  // ----------------------------------------------------------------
  // block geometry
  // ----------------------------------------------------------------
  localparam int RS_BLOCK_BITS  = 1792;
  localparam int HDR_BLOCK_BITS = 192;
  localparam int DATA_SYMS      = 252;
  localparam int PILOT_SYMS     = 4;
  localparam int CE_SYMS        = 768;
  localparam int DEMUX_BRANCHES = 4;
  localparam int UEP_BRANCHES   = 8;
  // ----------------------------------------------------------------
  // header field and generator seeds
  // ----------------------------------------------------------------
  localparam logic [5:0]  TXTS_VALUE = 6'h00;
  // scrambler and ce generator seeds and taps, values arbitrary
  localparam logic [14:0] SCR_SEED   = 15'h7FFF;
  localparam logic [14:0] SCR_TAPS   = 15'h6000;
  localparam logic [10:0] CE_SEED    = 11'h5A5;
  localparam logic [10:0] CE_TAPS    = 11'h500;
  // ----------------------------------------------------------------
  // modes, phases, states
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_BASIC = 2'h0;
  localparam logic [1:0] MODE_DQPSK = 2'h1;
  localparam logic [1:0] MODE_UEP   = 2'h2;
  localparam logic [1:0] PH_P1 = 2'h0;
  localparam logic [1:0] PH_PJ = 2'h1;
  localparam logic [1:0] PH_M1 = 2'h2;
  localparam logic [1:0] PH_MJ = 2'h3;
  typedef enum logic [1:0] {SA_DATA = 2'h1, SA_PAD = 2'h2} scpe_bits_e;
  typedef enum logic [2:0] {
    SC_DATA  = 3'h1,
    SC_PILOT = 3'h2,
    SC_CE    = 3'h4
  } scpe_sym_e;
endpackage

/* scpe_rs_model.sv */
// far-side model: rs coder, demux and bit interleave chain as an identity loopback
`timescale 1ns/1ps
module scpe_rs_model (
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  input  wire logic i_stall,
  input  wire logic i_enc_valid,
  input  wire logic i_enc_bit,
  input  wire logic i_enc_last,
  input  wire logic i_enc_raw,
  output logic      o_enc_ready,
  output logic      o_ret_valid,
  output logic      o_ret_bit,
  output logic      o_ret_last,
  output logic      o_ret_raw,
  input  wire logic i_ret_ready
);
  logic [2:0] fifo[$];
  logic       took;
  initial begin
    o_enc_ready = 1'b0;
    o_ret_valid = 1'b0;
    o_ret_bit   = 1'b0;
    o_ret_last  = 1'b0;
    o_ret_raw   = 1'b0;
    took        = 1'b0;
  end
  // ----------------------------------------------------------------
  // sampling edge: take coded input, retire the answered bit
  // ----------------------------------------------------------------
  always @(posedge i_mclk) begin
    if (!i_resetn) begin
      fifo.delete();
      took = 1'b0;
    end else begin
      took = o_ret_valid && i_ret_ready;
      if (took) void'(fifo.pop_front());
      if (i_enc_valid && o_enc_ready) fifo.push_back({i_enc_bit, i_enc_last, i_enc_raw});
    end
  end
  // ----------------------------------------------------------------
  // falling edge: all outputs move, released lines show inverted values
  // ----------------------------------------------------------------
  always @(negedge i_mclk) begin
    o_enc_ready <= i_resetn && !i_stall;
    if (!i_resetn || took) begin
      o_ret_valid <= 1'b0;
      o_ret_bit   <= ~o_ret_bit;
      o_ret_last  <= ~o_ret_last;
      o_ret_raw   <= ~o_ret_raw;
    end else if (!o_ret_valid && fifo.size() > 0 && !i_stall) begin
      o_ret_valid <= 1'b1;
      {o_ret_bit, o_ret_last, o_ret_raw} <= fifo[0];
    end
  end
endmodule

/* test_sc_payload_encoder.sv */
// testbench for the single-carrier payload encoder
`timescale 1ns/1ps
module test_sc_payload_encoder;
  logic       i_mclk, i_resetn, bit_valid, bit_val, bit_last, hdr, ce_req, sym_ready, stall;
  logic [1:0] mode;
  logic [3:0] tdsf;
  logic       o_bit_ready, o_rs_valid, o_rs_bit, o_rs_last, o_rs_raw, rs_ready;
  logic       ret_valid, ret_bit, ret_last, ret_raw, o_rs_ready;
  logic       o_sym_valid, o_sym_pilot, o_sym_ce, o_sym_last;
  logic [1:0] o_sym_re, o_sym_im;
  logic [5:0] o_tx_training_symbol_count;
  int         failures, n_checks;
  int         qr[$], qi[$];

  scpe_encoder uut (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_bit_valid(bit_valid), .i_bit(bit_val),
    .i_bit_last(bit_last), .i_hdr(hdr), .i_mode(mode), .o_bit_ready(o_bit_ready),
    .o_rs_valid(o_rs_valid), .o_rs_bit(o_rs_bit), .o_rs_last(o_rs_last), .o_rs_raw(o_rs_raw),
    .i_rs_ready(rs_ready), .i_rs_valid(ret_valid), .i_rs_bit(ret_bit), .i_rs_last(ret_last),
    .i_rs_raw(ret_raw), .o_rs_ready(o_rs_ready), .i_tdsf(tdsf), .i_ce_req(ce_req),
    .o_sym_valid(o_sym_valid), .o_sym_re(o_sym_re), .o_sym_im(o_sym_im),
    .o_sym_pilot(o_sym_pilot), .o_sym_ce(o_sym_ce), .o_sym_last(o_sym_last),
    .i_sym_ready(sym_ready), .o_tx_training_symbol_count(o_tx_training_symbol_count));

  scpe_rs_model rs_far (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_stall(stall), .i_enc_valid(o_rs_valid),
    .i_enc_bit(o_rs_bit), .i_enc_last(o_rs_last), .i_enc_raw(o_rs_raw), .o_enc_ready(rs_ready),
    .o_ret_valid(ret_valid), .o_ret_bit(ret_bit), .o_ret_last(ret_last), .o_ret_raw(ret_raw),
    .i_ret_ready(o_rs_ready));

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic timeout(input string what);
    failures++;
    $display("wrong value %s expected completion seen timeout", what);
    results();
  endtask
  function automatic logic [1:0] enc(input int v);
    return (v > 0) ? 2'h1 : ((v < 0) ? 2'h3 : 2'h0);
  endfunction
  task automatic push_pair(input logic a, input logic b);
    qr.push_back((a == b) ? (a ? 1 : -1) : 0);
    qi.push_back((a == b) ? 0 : (a ? -1 : 1));
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reset_test();
    chk("reset outputs", 16'h0, {6'h0, o_tx_training_symbol_count, o_rs_valid, o_sym_valid,
        o_sym_pilot, o_sym_last});
  endtask
  // one bit block: bits in, rs stream checked, mapped and framed symbols checked
  task automatic run_block(input logic h, input logic [1:0] m, input int nbits,
                           input logic [31:0] pat, input int rs_total, input int ntot);
    int ns, hb, half;
    ns = 0;
    half = 0;
    qr.delete();
    qi.delete();
    hdr <= h;
    mode <= m;
    fork
      begin
        int j, w;
        for (j = 0; j < nbits; j++) begin
          bit_valid <= 1'b1;
          bit_val <= pat[j];
          bit_last <= (j == nbits - 1);
          w = 0;
          do begin
            @(posedge i_mclk);
            w++;
          end while (!o_bit_ready && w < 20);
          if (w >= 20) timeout("bit accept");
          @(negedge i_mclk);
        end
        bit_valid <= 1'b0;
        bit_last <= 1'b0;
      end
      begin
        int r, w;
        r = 0;
        w = 0;
        while (r < rs_total && w < 20000) begin
          @(posedge i_mclk);
          w++;
          if (o_rs_valid && rs_ready) begin
            if (r >= nbits || h) chk("rs bit", {15'h0, (r < nbits) ? pat[r] : 1'b0}, {15'h0, o_rs_bit});
            chk("rs flags", {14'h0, h, r == rs_total - 1}, {14'h0, o_rs_raw, o_rs_last});
            r++;
          end
        end
        if (r < rs_total) timeout("rs stream");
      end
      begin
        int w, p, vr, vi, tr, ti, nr, pvr, pvi, rl, sp;
        w = 0;
        rl = 0;
        sp = (tdsf < 4'h2) ? 1 : int'(tdsf);
        vr = 0;
        vi = 0;
        tr = 0;
        ti = 0;
        pvr = 0;
        pvi = 0;
        while (ns < ntot && w < 30000) begin
          @(posedge i_mclk);
          w++;
          if (ret_valid && o_rs_ready) begin
            if (m == scpe_pkg::MODE_BASIC || h) begin
              qr.push_back(ret_bit ? 1 : -1);
              qi.push_back(0);
            end else if (half) begin
              push_pair(hb[0], ret_bit);
              half = 0;
            end else begin
              hb = ret_bit;
              half = 1;
            end
            if (ret_last && half) push_pair(hb[0], 1'b0);
          end
          if (o_sym_valid && sym_ready) begin
            p = ns % 256;
            if (p >= 252) begin
              chk("pilot", {9'h0, enc((p % 2) ? 1 : -1), 2'h0, 2'h2, ns == ntot - 1},
                  {9'h0, o_sym_re, o_sym_im, o_sym_pilot, o_sym_ce, o_sym_last});
            end else begin
              if (rl == 0) begin
                vr = 0;
                vi = 0;
                if (qr.size() > 0) begin
                  vr = qr.pop_front();
                  vi = qi.pop_front();
                  rl = sp;
                end
              end
              if (rl > 0) rl--;
              if (p == 0 || (m == scpe_pkg::MODE_UEP && !h) || (pvr == 0 && pvi == 0)
                  || (vr == 0 && vi == 0)) begin
                tr = vr;
                ti = vi;
              end else begin
                nr = tr * vr - ti * vi;
                ti = tr * vi + ti * vr;
                tr = nr;
              end
              pvr = vr;
              pvi = vi;
              chk("data", {9'h0, enc(tr), enc(ti), 3'h0},
                  {9'h0, o_sym_re, o_sym_im, o_sym_pilot, o_sym_ce, o_sym_last});
            end
            ns++;
          end
          @(negedge i_mclk);
          sym_ready <= (w % 7 != 3);
          stall <= (w % 11 == 5);
        end
        if (ns < ntot) timeout("symbol stream");
      end
    join
    chk("pad queue", 16'h0, qr.size());
  endtask
  task automatic ce_test();
    int n, w;
    n = 0;
    sym_ready <= 1'b1;
    ce_req <= 1'b1;
    @(negedge i_mclk);
    ce_req <= 1'b0;
    for (w = 0; w < 1200; w++) begin
      @(posedge i_mclk);
      if (o_sym_valid && sym_ready) begin
        chk("ce flags", 16'h0002, {11'h0, o_sym_im, o_sym_pilot, o_sym_ce, o_sym_last});
        chk("ce level", 16'h1, {15'h0, o_sym_re == 2'h1 || o_sym_re == 2'h3});
        n++;
      end
    end
    chk("ce count", 16'd768, n);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    n_checks = 0;
    i_resetn = 1'b0;
    {bit_valid, bit_val, bit_last, hdr, ce_req, stall} = 6'h0;
    sym_ready = 1'b1;
    mode = 2'h0;
    tdsf = 4'h0;
    repeat (16) @(negedge i_mclk);
    reset_test();
    i_resetn <= 1'b1;
    repeat (4) @(negedge i_mclk);
    run_block(1'b1, scpe_pkg::MODE_BASIC, 20, 32'h000B3A5C, 192, 512);
    repeat (10) @(negedge i_mclk);
    tdsf = 4'h2;
    run_block(1'b0, scpe_pkg::MODE_DQPSK, 13, 32'h00001A6D, 1792, 2048);
    repeat (10) @(negedge i_mclk);
    tdsf = 4'h0;
    run_block(1'b0, scpe_pkg::MODE_UEP, 13, 32'h00001A6D, 3584, 2048);
    repeat (10) @(negedge i_mclk);
    ce_test();
    chk("training count", 16'h0, {10'h0, o_tx_training_symbol_count});
    results();
  end
endmodule
